// ### dff_set_reset_regs.vh
// Constants for the edge-triggered storage element with asynchronous set and clear.
`ifndef DFF_SET_RESET_REGS_VH
`define DFF_SET_RESET_REGS_VH
`define SYNC_STAGES 3
`define TRUE_RESET_VALUE 1'h0
`define COMP_RESET_VALUE 1'h1
`endif

// ### d_flip_flop_set_reset.v
// Edge-triggered storage element with asynchronous set and clear and complementary outputs.
`timescale 1ns/1ps
`include "dff_set_reset_regs.vh"

module d_flip_flop_set_reset (
	input wire i_clock,
	input wire i_reset_n,
	input wire i_edge_clock_in,
	input wire i_data_in,
	input wire i_set_n_in,
	input wire i_clear_n_in,
	output reg o_true_out,
	output reg o_comp_out
);

	// Tracker states hold the last settled level seen on the clock pin.
	localparam [0:0] PIN_LOW = 1'h0;
	localparam [0:0] PIN_HIGH = 1'h1;

	// Pin modes decoded from the set and clear levels.
	localparam [1:0] MODE_RUN = 2'h0;
	localparam [1:0] MODE_SET = 2'h1;
	localparam [1:0] MODE_CLEAR = 2'h2;
	localparam [1:0] MODE_BOTH = 2'h3;

	// Stages whose agreement marks a settled clock pin level.
	localparam integer TAP_MID = `SYNC_STAGES - 2;
	localparam integer TAP_LAST = `SYNC_STAGES - 1;

	reg [`SYNC_STAGES-1:0] clk_sync_q;
	reg [`SYNC_STAGES-1:0] clk_sync_d;

	reg [`SYNC_STAGES-1:0] data_sync_q;
	reg [`SYNC_STAGES-1:0] data_sync_d;

	reg pin_state_q;
	reg pin_state_d;
	reg edge_seen;

	reg load_now;
	reg true_d;
	reg comp_d;
	reg [1:0] pin_mode_now;

	wire clk_settled;
	wire clk_level;
	wire data_taken;

	function [`SYNC_STAGES-1:0] shift_in;
		input [`SYNC_STAGES-1:0] stages;
		input pin_level;
		begin
			shift_in = {stages[`SYNC_STAGES-2:0], pin_level};
		end
	endfunction

	function stages_agree;
		input stage_a;
		input stage_b;
		begin
			stages_agree = (stage_a == stage_b);
		end
	endfunction

	// Next tracker state from the settled clock pin level.
	function [0:0] tracker_next;
		input [0:0] state;
		input settled;
		input level;
		begin
			tracker_next = state;
			case (state)
				PIN_LOW: begin
					if (settled && level) begin
						tracker_next = PIN_HIGH;
					end
				end
				PIN_HIGH: begin
					if (settled && !level) begin
						tracker_next = PIN_LOW;
					end
				end
				default: begin
					tracker_next = PIN_LOW;
				end
			endcase
		end
	endfunction

	function [1:0] pin_mode;
		input set_n;
		input clear_n;
		begin
			case ({set_n, clear_n})
				2'h3: pin_mode = MODE_RUN;
				2'h1: pin_mode = MODE_SET;
				2'h2: pin_mode = MODE_CLEAR;
				default: pin_mode = MODE_BOTH;
			endcase
		end
	endfunction

	// A counted edge loads only while both asynchronous pins are released.
	function run_edge;
		input load;
		input [1:0] mode;
		begin
			run_edge = load && (mode == MODE_RUN);
		end
	endfunction

	// Value pair that a clock edge leaves on the outputs, true bit first.
	function [1:0] edge_pair;
		input load;
		input data;
		input [1:0] held;
		begin
			if (load) begin
				edge_pair = {data, ~data};
			end else begin
				edge_pair = held;
			end
		end
	endfunction

	// Both pins pass the same three stages so data keeps its alignment to the clock pin.
	always @* begin
		clk_sync_d = shift_in(clk_sync_q, i_edge_clock_in);
		data_sync_d = shift_in(data_sync_q, i_data_in);
	end

	// Reset clears every stage, so a pin already high at release counts as one rising edge.
	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			clk_sync_q <= {`SYNC_STAGES{1'h0}};
		end else begin
			clk_sync_q <= clk_sync_d;
		end
	end

	// Data is sampled on every edge; only a counted clock edge makes use of it.
	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			data_sync_q <= {`SYNC_STAGES{1'h0}};
		end else begin
			data_sync_q <= data_sync_d;
		end
	end

	// A clock pin change only counts once the second and third stages agree.
	// A pin pulse shorter than two clock periods may therefore be missed.
	assign clk_settled = stages_agree(clk_sync_q[TAP_MID], clk_sync_q[TAP_LAST]);
	assign clk_level = clk_sync_q[TAP_LAST];
	assign data_taken = data_sync_q[TAP_LAST];

	always @* begin
		pin_mode_now = pin_mode(i_set_n_in, i_clear_n_in);
	end

	// The strobe is high in the single cycle in which the tracker moves from low to high.
	always @* begin
		pin_state_d = tracker_next(pin_state_q, clk_settled, clk_level);
		edge_seen = (pin_state_q == PIN_LOW) && (pin_state_d == PIN_HIGH);
	end

	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_state_q <= PIN_LOW;
		end else begin
			pin_state_q <= pin_state_d;
		end
	end

	// Outside a counted edge the next pair is the held pair, so nothing moves.
	always @* begin
		load_now = run_edge(edge_seen, pin_mode_now);
		{true_d, comp_d} = edge_pair(load_now, data_taken, {o_true_out, o_comp_out});
	end

	// The set and clear pins drive the output flops directly so that they act at once.
	// Release edges are in the list too, so that the other pin still held low takes over.
	// A set release in the cycle of a counted edge loads the new data a little early.
	always @(posedge i_clock or negedge i_reset_n or negedge i_set_n_in or
			negedge i_clear_n_in or posedge i_set_n_in) begin
		if (!i_set_n_in) begin
			o_true_out <= 1'h1;
		end else if (!i_clear_n_in) begin
			o_true_out <= 1'h0;
		end else if (!i_reset_n) begin
			o_true_out <= `TRUE_RESET_VALUE;
		end else begin
			o_true_out <= true_d;
		end
	end

	// The complement flop mirrors the true flop with set and clear swapped.
	always @(posedge i_clock or negedge i_reset_n or negedge i_set_n_in or
			negedge i_clear_n_in or posedge i_clear_n_in) begin
		if (!i_clear_n_in) begin
			o_comp_out <= 1'h1;
		end else if (!i_set_n_in) begin
			o_comp_out <= 1'h0;
		end else if (!i_reset_n) begin
			o_comp_out <= `COMP_RESET_VALUE;
		end else begin
			o_comp_out <= comp_d;
		end
	end

endmodule

// ### dff_chk_assertions.sv
// Flip-flop port checks.
`timescale 1ns/1ps
module dff_chk(input wire i_clock,i_reset_n,i_edge_clock_in,i_data_in,i_set_n_in,
	i_clear_n_in,o_true_out,o_comp_out);
default clocking @(posedge i_clock); endclocking
default disable iff (!i_reset_n);
wire r=i_set_n_in&i_clear_n_in;
wire [1:0] o={o_true_out,o_comp_out};
sequence rise; $rose(i_edge_clock_in)&&r; endsequence
sequence ld; rise ##1 (r&&$stable(i_data_in))[*4]; endsequence
sequence quiet; (r&&!i_edge_clock_in)[*5]; endsequence
sequence held_reset; !i_reset_n ##1 (!i_reset_n&&r); endsequence
a_async_force: assert property(!r|->o==~{i_set_n_in,i_clear_n_in})
	else $error("bad");
a_edge_load: assert property(ld|->o=={i_data_in,!i_data_in}) else $error("bad");
a_comp_inverse: assert property(ld|->o_comp_out!=o_true_out)
	else $error("complement not inverse after load");
a_no_early_load: assert property(rise ##1 r[*3]|->$stable(o))
	else $error("outputs moved before the counted edge");
a_quiet_hold: assert property(quiet|->$stable(o))
	else $error("outputs moved without a clock pin edge");
a_reset_value: assert property(disable iff (1'h0) held_reset|->o==2'h1)
	else $error("outputs wrong during reset");
endmodule
bind d_flip_flop_set_reset dff_chk u_chk(.*);

// ### pin_src.sv
// Pin clock and data source.
`timescale 1ns/1ps
module pin_src(input wire i_clock,output logic o_pin=0,o_d=0);
int n=0;
always @(negedge i_clock) begin n<=(n+1)%8; o_d<=n==1?^$urandom:o_d; o_pin<=n==3||o_pin&&n!=7; end
endmodule

// ### d_flip_flop_set_reset_tb.sv
// Random bench for the flip-flop.
`timescale 1ns/1ps
module d_flip_flop_set_reset_tb;
logic i_clock=0,rn=0,s=1,c=1,a=1,p,d,q,qn;
int errors=0,num_checks=0,k;
always #20 i_clock=~i_clock;
pin_src u_src(.i_clock,.o_pin(p),.o_d(d));
d_flip_flop_set_reset u_dut(.i_clock,.i_reset_n(rn),.i_edge_clock_in(p),.i_data_in(d),
	.i_set_n_in(s),.i_clear_n_in(c),.o_true_out(q),.o_comp_out(qn));
task chk(input logic [1:0] v); num_checks++;
	if({q,qn}!==v) begin errors++; $display("wrong value %0t outputs differ",$time); end endtask
task close_out; $display("errors %0d checks %0d",errors,num_checks);
	if(errors==0&&num_checks>0) $display("All tests passed");
	else $display("Some tests failed");
	$finish; endtask
initial #60000 begin errors++; close_out; end
initial begin void'($urandom(32'hE4CE)); repeat(20) @(negedge i_clock); rn=1;
	repeat(60) begin @(negedge p);
		if(a) {s,c,a}=3'h6; else begin chk({d,!d}); k=$urandom%4; a=k<3; end
		if(a) begin {s,c}=k[1:0]; #1 chk(~k[1:0]); end
	end close_out; end
endmodule
